// File: hw/fer_env_probe.sv
// Probe of the first and last environment bytes before an environment load commits.
`timescale 1ns/1ns
module fer_env_probe (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // Control
  input  wire logic start,
  // Memory probe
  output logic      rd_req_q,
  output logic      rd_last_q,
  input  wire logic rd_ack,
  input  wire logic rd_fault,
  // Result
  output logic      commit_q,
  output logic      abort_q
);

  fer_pkg::fer_probe_t st_q, st_d;
  logic                rd_req_d, rd_last_d, commit_d, abort_d;

  always_comb begin
    st_d      = st_q;
    rd_req_d  = rd_req_q;
    rd_last_d = rd_last_q;
    commit_d  = 1'b0;
    abort_d   = 1'b0;
    unique case (st_q)
      fer_pkg::PRB_IDLE: begin
        if (start) begin
          st_d      = fer_pkg::PRB_FIRST;
          rd_req_d  = 1'b1;
          rd_last_d = 1'b0;
        end
      end
      fer_pkg::PRB_FIRST: begin
        if (rd_fault) begin
          st_d     = fer_pkg::PRB_IDLE;
          rd_req_d = 1'b0;
          abort_d  = 1'b1;
        end else if (rd_ack) begin
          st_d      = fer_pkg::PRB_LAST;
          rd_last_d = 1'b1;
        end
      end
      fer_pkg::PRB_LAST: begin
        st_d      = fer_pkg::PRB_IDLE;
        rd_req_d  = (rd_fault || rd_ack) ? 1'b0 : 1'b1;
        rd_last_d = (rd_fault || rd_ack) ? 1'b0 : 1'b1;
        if (rd_fault) begin
          abort_d  = 1'b1;
        end else if (rd_ack) begin
          commit_d = 1'b1;
        end else begin
          st_d     = fer_pkg::PRB_LAST;
        end
      end
      default: begin
        st_d     = fer_pkg::PRB_IDLE;
        rd_req_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q      <= fer_pkg::PRB_IDLE;
      rd_req_q  <= fer_pkg::RST_FLAG;
      rd_last_q <= fer_pkg::RST_FLAG;
      commit_q  <= fer_pkg::RST_FLAG;
      abort_q   <= fer_pkg::RST_FLAG;
    end else begin
      st_q      <= st_d;
      rd_req_q  <= rd_req_d;
      rd_last_q <= rd_last_d;
      commit_q  <= commit_d;
      abort_q   <= abort_d;
    end
  end

  property p_commit_after_last;
    @(posedge core_clk) disable iff (srst)
      commit_q |-> $past(rd_last_q) && $past(rd_ack);
  endproperty
  a_commit_after_last: assert property (p_commit_after_last) else $error("commit without last-byte probe");

endmodule : fer_env_probe

// File: hw/fer_exc_unit.sv
// Floating-point exception detection and reporting unit.
`timescale 1ns/1ns
module fer_exc_unit (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             srst,
  // Control state
  input  wire logic             task_switched_flag,
  input  wire logic             emulation_flag,
  input  wire logic             ac_enable,
  input  wire logic [1:0]       cpl,
  // Instruction issue
  input  wire logic             issue_valid,
  input  wire fer_pkg::fer_op_t issue_op,
  input  wire logic             issue_undef,
  input  wire logic [15:0]      issue_cs,
  input  wire logic [31:0]      issue_ip,
  input  wire logic             issue_beyond_limit,
  input  wire logic             issue_misaligned,
  input  wire logic             issue_stack_part,
  input  wire logic             issue_overrun,
  input  wire logic             issue_denormal,
  // Fault report
  output logic                  fault_valid_q,
  output logic [7:0]            fault_vector_q,
  output logic [15:0]           fault_cs_q,
  output logic [31:0]           fault_ip_q,
  output logic                  abort_q,
  // Execution start
  output logic                  exec_start_q,
  output fer_pkg::fer_op_t      exec_op_q,
  output logic                  normalize_q,
  output logic                  rem_nearest_q,
  // Environment probe
  output logic                  env_rd_req_q,
  output logic                  env_rd_last_q,
  input  wire logic             env_rd_ack,
  input  wire logic             env_rd_fault,
  output logic                  env_commit_q,
  output logic                  env_abort_q,
  // Completion
  input  wire logic             done_valid,
  input  wire fer_pkg::fer_op_t done_op,
  input  wire logic             done_unmasked_exc,
  input  wire logic             done_inexact,
  input  wire logic             done_masked_uf,
  input  wire logic             done_underflow,
  input  wire logic             done_st1_frac,
  input  wire logic [2:0]       done_quot,
  input  wire logic             err_clear,
  // Status
  output logic                  fp_error_out_q,
  output logic                  precision_q,
  output logic                  underflow_q,
  output logic                  scale_hold_q,
  output logic                  cc_valid_q,
  output logic                  cc0_q,
  output logic                  cc1_q,
  output logic                  cc3_q
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic norm_op(input fer_pkg::fer_op_t op);
    norm_op = (op == fer_pkg::OP_SQRT) || (op == fer_pkg::OP_DIV) ||
              (op == fer_pkg::OP_PREM) || (op == fer_pkg::OP_CONV);
  endfunction : norm_op

  // ----------------------------------------
  // Fault selection
  // ----------------------------------------
  fer_pkg::fer_err_t err_q, err_d;
  logic              arb_take;
  logic [7:0]        arb_vector;
  logic              arb_abort;
  logic              issue_runs;

  fer_fault_arb u_arb (
    .task_switched_flag (task_switched_flag),
    .emulation_flag     (emulation_flag),
    .ac_enable          (ac_enable),
    .cpl                (cpl),
    .err_pending        (err_q == fer_pkg::ERR_PEND),
    .undef              (issue_undef),
    .beyond_limit       (issue_beyond_limit),
    .misaligned         (issue_misaligned),
    .stack_part         (issue_stack_part),
    .overrun            (issue_overrun),
    .take               (arb_take),
    .vector             (arb_vector),
    .abort              (arb_abort)
  );

  assign issue_runs = issue_valid && !arb_take && !arb_abort;

  // ----------------------------------------
  // Environment probe
  // ----------------------------------------
  fer_env_probe u_probe (
    .core_clk  (core_clk),
    .srst      (srst),
    .start     (issue_runs && issue_op == fer_pkg::OP_LDENV),
    .rd_req_q  (env_rd_req_q),
    .rd_last_q (env_rd_last_q),
    .rd_ack    (env_rd_ack),
    .rd_fault  (env_rd_fault),
    .commit_q  (env_commit_q),
    .abort_q   (env_abort_q)
  );

  // ----------------------------------------
  // Issue side
  // ----------------------------------------
  logic             fault_valid_d, abort_d, exec_start_d, normalize_d, rem_nearest_d;
  logic [7:0]       fault_vector_d;
  logic [15:0]      fault_cs_d;
  logic [31:0]      fault_ip_d;
  fer_pkg::fer_op_t exec_op_d;

  always_comb begin
    fault_valid_d  = issue_valid && arb_take;
    fault_vector_d = fault_vector_q;
    fault_cs_d     = fault_cs_q;
    fault_ip_d     = fault_ip_q;
    abort_d        = issue_valid && arb_abort;
    exec_start_d   = issue_runs && issue_op != fer_pkg::OP_LDENV;
    exec_op_d      = exec_op_q;
    normalize_d    = 1'b0;
    rem_nearest_d  = 1'b0;
    if (issue_valid && arb_take) begin
      // Faults are reported on this port; pending errors also reach an interrupt controller via fp_error_out_q.
      fault_vector_d = arb_vector;
      fault_cs_d     = issue_cs;
      fault_ip_d     = issue_ip;
    end
    if (issue_runs) begin
      exec_op_d     = issue_op;
      normalize_d   = issue_denormal && norm_op(issue_op);
      rem_nearest_d = issue_op == fer_pkg::OP_PREM1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      fault_valid_q  <= fer_pkg::RST_FLAG;
      fault_vector_q <= fer_pkg::RST_VECTOR;
      fault_cs_q     <= '0;
      fault_ip_q     <= '0;
      abort_q        <= fer_pkg::RST_FLAG;
      exec_start_q   <= fer_pkg::RST_FLAG;
      exec_op_q      <= fer_pkg::OP_OTHER;
      normalize_q    <= fer_pkg::RST_FLAG;
      rem_nearest_q  <= fer_pkg::RST_FLAG;
    end else begin
      fault_valid_q  <= fault_valid_d;
      fault_vector_q <= fault_vector_d;
      fault_cs_q     <= fault_cs_d;
      fault_ip_q     <= fault_ip_d;
      abort_q        <= abort_d;
      exec_start_q   <= exec_start_d;
      exec_op_q      <= exec_op_d;
      normalize_q    <= normalize_d;
      rem_nearest_q  <= rem_nearest_d;
    end
  end

  // ----------------------------------------
  // Pending error and completion flags
  // ----------------------------------------
  logic precision_d, underflow_d, scale_hold_d, cc_valid_d, cc0_d, cc1_d, cc3_d;

  always_comb begin
    err_d        = err_q;
    precision_d  = precision_q;
    underflow_d  = underflow_q;
    scale_hold_d = scale_hold_q;
    cc_valid_d   = 1'b0;
    cc0_d        = cc0_q;
    cc1_d        = cc1_q;
    cc3_d        = cc3_q;
    unique case (err_q)
      fer_pkg::ERR_IDLE: begin
        if (done_valid && done_unmasked_exc) begin
          err_d = fer_pkg::ERR_PEND;
        end
      end
      fer_pkg::ERR_PEND: begin
        // A new unmasked completion in the clear cycle keeps the error pending.
        if (err_clear && !(done_valid && done_unmasked_exc)) begin
          err_d = fer_pkg::ERR_IDLE;
        end
      end
    endcase
    if (done_valid) begin
      underflow_d  = done_underflow;
      precision_d  = done_inexact;
      scale_hold_d = 1'b0;
      if (done_op == fer_pkg::OP_SCALE) begin
        precision_d  = done_inexact || done_masked_uf;
        scale_hold_d = done_st1_frac;
      end
      if (done_op == fer_pkg::OP_PREM) begin
        cc_valid_d = 1'b1;
        cc0_d      = done_quot[2];
        cc3_d      = done_quot[1];
        cc1_d      = done_quot[0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      err_q          <= fer_pkg::ERR_IDLE;
      fp_error_out_q <= fer_pkg::RST_FLAG;
      precision_q    <= fer_pkg::RST_FLAG;
      underflow_q    <= fer_pkg::RST_FLAG;
      scale_hold_q   <= fer_pkg::RST_FLAG;
      cc_valid_q     <= fer_pkg::RST_FLAG;
      cc0_q          <= fer_pkg::RST_FLAG;
      cc1_q          <= fer_pkg::RST_FLAG;
      cc3_q          <= fer_pkg::RST_FLAG;
    end else begin
      err_q          <= err_d;
      fp_error_out_q <= err_d == fer_pkg::ERR_PEND;
      precision_q    <= precision_d;
      underflow_q    <= underflow_d;
      scale_hold_q   <= scale_hold_d;
      cc_valid_q     <= cc_valid_d;
      cc0_q          <= cc0_d;
      cc1_q          <= cc1_d;
      cc3_q          <= cc3_d;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  property p_fp_error_out_done;
    done_valid && done_unmasked_exc |=> fp_error_out_q;
  endproperty
  a_fp_error_out_done: assert property (p_fp_error_out_done) else $error("error output missed at completion");

  property p_nm;
    issue_valid && (task_switched_flag || emulation_flag) |=> fault_valid_q && fault_vector_q == fer_pkg::VEC_NM;
  endproperty
  a_nm: assert property (p_nm) else $error("device unavailable fault missing");

  property p_ud;
    issue_valid && !task_switched_flag && !emulation_flag && issue_undef
      |=> fault_valid_q && fault_vector_q == fer_pkg::VEC_UD && !exec_start_q;
  endproperty
  a_ud: assert property (p_ud) else $error("undefined opcode not reported as invalid opcode");

  property p_block;
    issue_valid && err_q == fer_pkg::ERR_PEND && !issue_undef && !task_switched_flag && !emulation_flag
      |=> fault_vector_q == fer_pkg::VEC_MF && !exec_start_q && !env_rd_req_q;
  endproperty
  a_block: assert property (p_block) else $error("instruction ran with error pending");

  property p_ptr;
    issue_valid |=> !fault_valid_q || (fault_ip_q == $past(issue_ip) && fault_cs_q == $past(issue_cs));
  endproperty
  a_ptr: assert property (p_ptr) else $error("saved pointer is not the prefix address");

  property p_no_overrun;
    fault_valid_q |-> fault_vector_q != fer_pkg::VEC_OVERRUN;
  endproperty
  a_no_overrun: assert property (p_no_overrun) else $error("overrun vector raised");

  property p_gp;
    issue_valid && issue_beyond_limit && !issue_undef && err_q == fer_pkg::ERR_IDLE
      && !task_switched_flag && !emulation_flag |=> fault_vector_q == fer_pkg::VEC_GP;
  endproperty
  a_gp: assert property (p_gp) else $error("segment limit fault missing");

  property p_norm;
    issue_valid && !arb_take && !arb_abort && issue_denormal && issue_op == fer_pkg::OP_DIV
      |=> normalize_q && exec_start_q;
  endproperty
  a_norm: assert property (p_norm) else $error("denormal divide not normalized");

  property p_quot;
    done_valid && done_op == fer_pkg::OP_PREM
      |=> cc0_q == $past(done_quot[2]) && cc3_q == $past(done_quot[1]) && cc1_q == $past(done_quot[0]);
  endproperty
  a_quot: assert property (p_quot) else $error("quotient bits misplaced");

  property p_scale;
    done_valid && done_op == fer_pkg::OP_SCALE
      |=> scale_hold_q == $past(done_st1_frac) && precision_q == $past(done_inexact || done_masked_uf);
  endproperty
  a_scale: assert property (p_scale) else $error("scale flags wrong");

  c_mf: cover property (fault_valid_q && fault_vector_q == fer_pkg::VEC_MF);
  c_env: cover property (env_commit_q);
  c_clear: cover property (err_q == fer_pkg::ERR_PEND ##1 err_q == fer_pkg::ERR_IDLE);

endmodule : fer_exc_unit

// File: hw/fer_fault_arb.sv
// Fault priority selection for one issued floating-point instruction.
`timescale 1ns/1ns
module fer_fault_arb (
  // Control state
  input  wire logic       task_switched_flag,
  input  wire logic       emulation_flag,
  input  wire logic       ac_enable,
  input  wire logic [1:0] cpl,
  input  wire logic       err_pending,
  // Instruction attributes
  input  wire logic       undef,
  input  wire logic       beyond_limit,
  input  wire logic       misaligned,
  input  wire logic       stack_part,
  input  wire logic       overrun,
  // Selection
  output logic            take,
  output logic [7:0]      vector,
  output logic            abort
);

  always_comb begin
    take   = 1'b0;
    vector = fer_pkg::RST_VECTOR;
    abort  = 1'b0;
    if (task_switched_flag || emulation_flag) begin
      take   = 1'b1;
      vector = fer_pkg::VEC_NM;
    end else if (undef) begin
      // Pending errors are not looked at for an undefined opcode.
      take   = 1'b1;
      vector = fer_pkg::VEC_UD;
    end else if (err_pending) begin
      take   = 1'b1;
      vector = fer_pkg::VEC_MF;
    end else if (beyond_limit) begin
      take   = 1'b1;
      vector = fer_pkg::VEC_GP;
    end else if (ac_enable && cpl == fer_pkg::PRIV_USER && misaligned && !stack_part) begin
      take   = 1'b1;
      vector = fer_pkg::VEC_AC;
    end else if (overrun) begin
      abort  = 1'b1;
    end
  end

endmodule : fer_fault_arb

// File: hw/fer_pkg.sv
// Shared constants and types for the floating-point exception reporting unit.
package fer_pkg;

  // ----------------------------------------
  // Exception vectors
  // ----------------------------------------
  localparam logic [7:0] VEC_UD      = 8'h06;
  localparam logic [7:0] VEC_NM      = 8'h07;
  localparam logic [7:0] VEC_OVERRUN = 8'h09;
  localparam logic [7:0] VEC_GP      = 8'h0D;
  localparam logic [7:0] VEC_MF      = 8'h10;
  localparam logic [7:0] VEC_AC      = 8'h11;

  // ----------------------------------------
  // Privilege and reset values
  // ----------------------------------------
  localparam logic [1:0] PRIV_USER   = 2'h3;
  localparam logic       RST_FLAG    = 1'h0;
  localparam logic [7:0] RST_VECTOR  = 8'h00;

  // ----------------------------------------
  // Operation classes
  // ----------------------------------------
  typedef enum logic [2:0] {
    OP_OTHER = 3'h0,
    OP_SQRT  = 3'h1,
    OP_DIV   = 3'h2,
    OP_PREM  = 3'h3,
    OP_PREM1 = 3'h4,
    OP_SCALE = 3'h5,
    OP_CONV  = 3'h6,
    OP_LDENV = 3'h7
  } fer_op_t;

  // ----------------------------------------
  // State machines
  // ----------------------------------------
  typedef enum logic {
    ERR_IDLE = 1'b0,
    ERR_PEND = 1'b1
  } fer_err_t;

  typedef enum logic [1:0] {
    PRB_IDLE  = 2'b00,
    PRB_FIRST = 2'b01,
    PRB_LAST  = 2'b11
  } fer_probe_t;

endpackage : fer_pkg

// File: tb/fer_exc_unit_bench.sv
// Self-checking testbench of the exception reporting unit.
`timescale 1ns/1ns
module fer_exc_unit_bench;
  logic              core_clk, srst, task_switched_flag, emulation_flag, ac_enable, issue_valid;
  logic [1:0]        cpl, fault_sel;
  fer_pkg::fer_op_t  issue_op, exec_op_q, done_op;
  logic              issue_undef, issue_beyond_limit, issue_misaligned, issue_stack_part;
  logic              issue_overrun, issue_denormal, slow, interrupt_request_in;
  logic [15:0]       issue_cs, fault_cs_q;
  logic [31:0]       issue_ip, fault_ip_q;
  logic              fault_valid_q, abort_q, exec_start_q, normalize_q, rem_nearest_q;
  logic [7:0]        fault_vector_q;
  logic              env_rd_req_q, env_rd_last_q, env_rd_ack, env_rd_fault, env_commit_q, env_abort_q;
  logic              done_valid, done_unmasked_exc, done_inexact, done_masked_uf, done_underflow;
  logic              done_st1_frac, err_clear, fp_error_out_q, precision_q, underflow_q, scale_hold_q;
  logic              cc_valid_q, cc0_q, cc1_q, cc3_q;
  logic [2:0]        done_quot;
  int                miscompares, n_tests;
  fer_pkg::fer_op_t  dn_ops[4];

  fer_exc_unit uut (.core_clk, .srst, .task_switched_flag, .emulation_flag, .ac_enable, .cpl,
    .issue_valid, .issue_op, .issue_undef, .issue_cs, .issue_ip, .issue_beyond_limit,
    .issue_misaligned, .issue_stack_part, .issue_overrun, .issue_denormal, .fault_valid_q,
    .fault_vector_q, .fault_cs_q, .fault_ip_q, .abort_q, .exec_start_q, .exec_op_q, .normalize_q,
    .rem_nearest_q, .env_rd_req_q, .env_rd_last_q, .env_rd_ack, .env_rd_fault, .env_commit_q,
    .env_abort_q, .done_valid, .done_op, .done_unmasked_exc, .done_inexact, .done_masked_uf,
    .done_underflow, .done_st1_frac, .done_quot, .err_clear, .fp_error_out_q, .precision_q,
    .underflow_q, .scale_hold_q, .cc_valid_q, .cc0_q, .cc1_q, .cc3_q);

  fer_mem_model partner (.core_clk, .srst, .env_rd_req_q, .env_rd_last_q, .env_rd_ack,
    .env_rd_fault, .slow, .fault_sel, .fp_error_out_q, .interrupt_request_in);

  // ----------------------------------------
  // Checking and access tasks
  // ----------------------------------------
  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic chk_vec(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_vec

  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic ctl(input logic t, input logic e, input logic a, input logic [1:0] p);
    @(posedge core_clk);
    task_switched_flag <= t;
    emulation_flag     <= e;
    ac_enable          <= a;
    cpl                <= p;
  endtask : ctl

  // Attributes are undef, beyond limit, misaligned, stack part, overrun; kind 0 run 1 fault 2 abort.
  task automatic issue_chk(input fer_pkg::fer_op_t op, input logic [4:0] at, input logic dn,
                           input logic [1:0] kind, input logic [7:0] v);
    @(posedge core_clk);
    issue_valid <= 1'b1;
    issue_op    <= op;
    {issue_undef, issue_beyond_limit, issue_misaligned, issue_stack_part, issue_overrun} <= at;
    issue_denormal <= dn;
    issue_cs    <= issue_cs + 16'h0001;
    issue_ip    <= issue_ip + 32'h00000010;
    @(posedge core_clk);
    issue_valid <= 1'b0;
    #1;
    chk_bit("exec_start_q", kind == 2'h0, exec_start_q);
    chk_bit("fault_valid_q", kind == 2'h1, fault_valid_q);
    chk_bit("abort_q", kind == 2'h2, abort_q);
    if (kind == 2'h1) begin
      chk_vec("fault_vector_q", {24'h000000, v}, {24'h000000, fault_vector_q});
      chk_vec("fault_cs_q", {16'h0000, issue_cs}, {16'h0000, fault_cs_q});
      chk_vec("fault_ip_q", issue_ip, fault_ip_q);
    end
  endtask : issue_chk

  task automatic done(input fer_pkg::fer_op_t op, input logic [4:0] fl, input logic [2:0] q);
    @(posedge core_clk);
    done_valid <= 1'b1;
    done_op    <= op;
    {done_unmasked_exc, done_inexact, done_masked_uf, done_underflow, done_st1_frac} <= fl;
    done_quot  <= q;
    @(posedge core_clk);
    done_valid <= 1'b0;
    #1;
  endtask : done

  task automatic env_run(input logic [1:0] f, input logic s, input logic ok);
    fault_sel = f;
    slow      = s;
    issue_chk(fer_pkg::OP_LDENV, 5'h00, 1'b0, 2'h3, 8'h00);
    chk_bit("env_rd_req_q", 1'b1, env_rd_req_q);
    chk_bit("env_rd_last_q", 1'b0, env_rd_last_q);
    for (int i = 0; i < 30 && !(env_commit_q || env_abort_q); i++) @(posedge core_clk) #1;
    chk_bit("env_commit_q", ok, env_commit_q);
    chk_bit("env_abort_q", !ok, env_abort_q);
  endtask : env_run

  // ----------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  initial begin
    repeat (4000) @(posedge core_clk);
    miscompares++;
    report_and_stop();
  end

  initial begin
    {srst, task_switched_flag, emulation_flag, ac_enable, issue_valid, issue_undef} = 6'h20;
    {issue_beyond_limit, issue_misaligned, issue_stack_part, issue_overrun, issue_denormal} = 5'h00;
    {done_valid, done_unmasked_exc, done_inexact, done_masked_uf, done_underflow} = 5'h00;
    {done_st1_frac, err_clear, slow, cpl, fault_sel, done_quot} = 10'h000;
    issue_op = fer_pkg::OP_OTHER;
    done_op  = fer_pkg::OP_OTHER;
    issue_cs = 16'h1200;
    issue_ip = 32'h00004000;
    dn_ops   = '{fer_pkg::OP_SQRT, fer_pkg::OP_DIV, fer_pkg::OP_PREM, fer_pkg::OP_CONV};
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    #1;
    chk_bit("fp_error_out_q", 1'b0, fp_error_out_q);
    chk_vec("exec_op_q", 32'h0, 32'(exec_op_q));
    ctl(1'b1, 1'b0, 1'b0, 2'h0);
    issue_chk(fer_pkg::OP_DIV, 5'h10, 1'b0, 2'h1, fer_pkg::VEC_NM);
    ctl(1'b0, 1'b1, 1'b0, 2'h0);
    issue_chk(fer_pkg::OP_OTHER, 5'h00, 1'b0, 2'h1, fer_pkg::VEC_NM);
    ctl(1'b0, 1'b0, 1'b1, 2'h3);
    issue_chk(fer_pkg::OP_OTHER, 5'h10, 1'b0, 2'h1, fer_pkg::VEC_UD);
    issue_chk(fer_pkg::OP_OTHER, 5'h08, 1'b0, 2'h1, fer_pkg::VEC_GP);
    issue_chk(fer_pkg::OP_OTHER, 5'h04, 1'b0, 2'h1, fer_pkg::VEC_AC);
    issue_chk(fer_pkg::OP_OTHER, 5'h06, 1'b0, 2'h0, 8'h00);
    issue_chk(fer_pkg::OP_OTHER, 5'h01, 1'b0, 2'h2, 8'h00);
    ctl(1'b0, 1'b0, 1'b1, 2'h2);
    issue_chk(fer_pkg::OP_OTHER, 5'h04, 1'b0, 2'h0, 8'h00);
    ctl(1'b0, 1'b0, 1'b0, 2'h3);
    issue_chk(fer_pkg::OP_OTHER, 5'h04, 1'b0, 2'h0, 8'h00);
    for (int i = 0; i < 4; i++) begin
      issue_chk(dn_ops[i], 5'h00, 1'b1, 2'h0, 8'h00);
      chk_bit("normalize_q", 1'b1, normalize_q);
      chk_vec("exec_op_q", 32'(dn_ops[i]), 32'(exec_op_q));
    end
    issue_chk(fer_pkg::OP_PREM1, 5'h00, 1'b0, 2'h0, 8'h00);
    chk_bit("rem_nearest_q", 1'b1, rem_nearest_q);
    chk_bit("normalize_q", 1'b0, normalize_q);
    done(fer_pkg::OP_SCALE, 5'h05, 3'h0);
    chk_bit("precision_q", 1'b1, precision_q);
    chk_bit("scale_hold_q", 1'b1, scale_hold_q);
    done(fer_pkg::OP_SCALE, 5'h00, 3'h0);
    chk_bit("precision_q", 1'b0, precision_q);
    chk_bit("scale_hold_q", 1'b0, scale_hold_q);
    done(fer_pkg::OP_DIV, 5'h06, 3'h0);
    chk_bit("precision_q", 1'b0, precision_q);
    chk_bit("underflow_q", 1'b1, underflow_q);
    for (int q = 0; q < 8; q++) begin
      done(fer_pkg::OP_PREM, 5'h00, 3'(q));
      chk_bit("cc_valid_q", 1'b1, cc_valid_q);
      chk_vec("cond_codes", 32'(q), {29'h0, cc0_q, cc3_q, cc1_q});
    end
    done(fer_pkg::OP_DIV, 5'h10, 3'h0);
    chk_bit("fp_error_out_q", 1'b1, fp_error_out_q);
    chk_bit("interrupt_request_in", 1'b1, interrupt_request_in);
    issue_chk(fer_pkg::OP_DIV, 5'h00, 1'b0, 2'h1, fer_pkg::VEC_MF);
    issue_chk(fer_pkg::OP_DIV, 5'h10, 1'b0, 2'h1, fer_pkg::VEC_UD);
    chk_bit("fp_error_out_q", 1'b1, fp_error_out_q);
    // A clear that meets a new unmasked completion must leave the error pending.
    @(posedge core_clk);
    {err_clear, done_valid, done_unmasked_exc} <= 3'h7;
    @(posedge core_clk);
    {err_clear, done_valid, done_unmasked_exc} <= 3'h0;
    #1;
    chk_bit("fp_error_out_q", 1'b1, fp_error_out_q);
    @(posedge core_clk);
    err_clear <= 1'b1;
    @(posedge core_clk);
    err_clear <= 1'b0;
    #1;
    chk_bit("fp_error_out_q", 1'b0, fp_error_out_q);
    issue_chk(fer_pkg::OP_DIV, 5'h00, 1'b0, 2'h0, 8'h00);
    env_run(2'h0, 1'b0, 1'b1);
    env_run(2'h0, 1'b1, 1'b1);
    env_run(2'h1, 1'b0, 1'b0);
    env_run(2'h2, 1'b1, 1'b0);
    // A reset in mid-run drops the pending error and the saved vector.
    done(fer_pkg::OP_DIV, 5'h10, 3'h0);
    chk_bit("fp_error_out_q", 1'b1, fp_error_out_q);
    @(posedge core_clk);
    srst <= 1'b1;
    @(posedge core_clk);
    srst <= 1'b0;
    #1;
    chk_bit("fp_error_out_q", 1'b0, fp_error_out_q);
    chk_vec("fault_vector_q", 32'h0, {24'h000000, fault_vector_q});
    issue_chk(fer_pkg::OP_DIV, 5'h00, 1'b0, 2'h0, 8'h00);
    report_and_stop();
  end
endmodule : fer_exc_unit_bench

// File: tb/fer_mem_model.sv
// Memory and interrupt controller model facing the exception unit.
`timescale 1ns/1ns
module fer_mem_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  // Probe reads
  input  wire logic       env_rd_req_q,
  input  wire logic       env_rd_last_q,
  output logic            env_rd_ack,
  output logic            env_rd_fault,
  // Scenario control
  input  wire logic       slow,
  input  wire logic [1:0] fault_sel,
  // Interrupt path
  input  wire logic       fp_error_out_q,
  output logic            interrupt_request_in
);
  logic       held;
  logic       acked_last;
  logic [1:0] cnt;

  // The error output reaches the core only as an external request.
  assign interrupt_request_in = fp_error_out_q;

  // Each probe phase is answered once, after zero or three idle cycles.
  always @(posedge core_clk) begin
    env_rd_ack   <= 1'b0;
    env_rd_fault <= 1'b0;
    if (srst || !env_rd_req_q || (held && env_rd_last_q != acked_last)) begin
      held <= 1'b0;
      cnt  <= 2'h0;
    end else if (!held) begin
      if (cnt == (slow ? 2'h3 : 2'h0)) begin
        held       <= 1'b1;
        acked_last <= env_rd_last_q;
        if (fault_sel[env_rd_last_q]) env_rd_fault <= 1'b1;
        else env_rd_ack <= 1'b1;
      end else begin
        cnt <= cnt + 2'h1;
      end
    end
  end
endmodule : fer_mem_model
